//--- rtl/bus_cond.sv
`timescale 1ns/1ns
module bus_cond (
  input wire logic ref_clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic scl_in, // synchronised link clock
  input wire logic sda_in, // synchronised link data
  output expander_pkg::bus_ev_t ev_out // one-cycle link events
);
  import expander_pkg::*;

  logic scl_q; // link clock one cycle ago
  logic sda_q; // link data one cycle ago

  // history of both lines, idle high
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // data moving while clock stays high marks start or stop
  assign ev_out.start = scl_in && scl_q && sda_q && !sda_in;
  assign ev_out.stop = scl_in && scl_q && !sda_q && sda_in;
  assign ev_out.scl_rise = scl_in && !scl_q;
  assign ev_out.scl_fall = !scl_in && scl_q;
endmodule

//--- rtl/expander_pkg.sv
package expander_pkg;
  // register select codes held in the low command bits
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_OUTPUT = 2'h1;
  localparam logic [1:0] SEL_INVERT = 2'h2;
  localparam logic [1:0] SEL_DIR = 2'h3;
  // fixed upper nibble of the 7-bit target address
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  // position of the direction bit in the address byte
  localparam int RW_BIT = 0;
  // bits per byte on the link, as a counter value
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  // reset values
  localparam logic [7:0] OUT_LATCH_RST = 8'hFF;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] POINTER_RST = 8'h00;

  // one-cycle link events found from the sampled clock and data
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } bus_ev_t;

  // link engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } state_t;

  // which byte of a write transfer is being received
  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_CMD = 3'h2,
    PH_DATA = 3'h4
  } phase_t;
endpackage

//--- rtl/serial_eight_bit_io_expander.sv
`timescale 1ns/1ns
// What this block does
// RQ1: answer address 0111 plus three strap inputs
// RQ2: last address bit one means read
// RQ3: first byte after write address is command
// RQ4: two low command bits pick register
// RQ5: command only in writes, pointer persists
// RQ6: input register shows all pin levels
// RQ7: writes to input register acked, discarded
// RQ8: latch drives only pins set output
// RQ9: latch read returns flip-flops, not pins
// RQ10: polarity bit one inverts reported input
// RQ11: direction one releases pin, zero drives
// RQ12: write bytes land in selected register, unlimited
// RQ13: master writes command, restarts, then reads
// RQ14: restart keeps currently selected register
// RQ15: read data captured at ack clock rise
// RQ16: master ends read by withholding ack
// RQ17: pointer at zero allows direct input read
// RQ18: stop anywhere releases data, returns idle
// RQ19: input edges raise interrupt; read clears
// RQ20: output pins never raise interrupt
// RQ21: acknowledge each received byte by pulling low
// RQ22: wrong address gets no ack, bus left alone
// RQ23: command bits above two are ignored
// RQ24: reset selects input register, engine idle
module serial_eight_bit_io_expander (
  input wire logic ref_clk_in, // 100 MHz system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic scl_in, // link clock pin level
  input wire logic sda_in, // link data pin level
  output logic sda_out, // link data drive value, always low
  output logic sda_oe_n_out, // low while pulling link data low
  input wire logic addr_strap_0_in, // address strap, bit 0
  input wire logic addr_strap_1_in, // address strap, bit 1
  input wire logic addr_strap_2_in, // address strap, bit 2
  input wire logic [7:0] port_pin_in, // port pin levels
  output logic [7:0] port_pin_out, // port pin drive values
  output logic [7:0] port_pin_oe_n_out, // low where the pin is driven
  output logic int_n_out, // interrupt drive value, always low
  output logic int_oe_n_out // low while the interrupt is raised
);
  import expander_pkg::*;

  logic [12:0] raw_in; // every outside level, gathered
  logic [12:0] sync_q; // the same after two flip-flops
  logic scl_s; // synced link clock
  logic sda_s; // synced link data
  logic [2:0] strap_s; // synced address straps
  logic [7:0] pin_s; // synced port pins
  bus_ev_t ev; // link events this cycle

  state_t state; // link engine state
  state_t next_state; // its next value
  phase_t phase; // role of the byte being received
  logic [3:0] bit_cnt; // clock rises seen in this byte
  logic [7:0] rx_shift; // byte being received
  logic [7:0] tx_shift; // byte being sent, msb on the wire
  logic [7:0] next_tx_shift; // its next value
  logic rw_read; // current transfer reads from us
  logic mack_ok; // master acknowledged the last byte
  logic next_sda_oe_n; // next data line enable

  logic [7:0] register_pointer; // last command byte
  logic [7:0] output_latch; // output latch flip-flops
  logic [7:0] input_polarity_invert; // per-pin inversion of reports
  logic [7:0] pin_direction; // one marks an input pin
  logic [7:0] in_snapshot; // pin levels at the last input read
  logic int_pend; // some input pin differs from the snapshot
  logic [1:0] settle_cnt; // cycles since reset, stops at three
  logic settling; // synchronisers still show their reset ones

  logic [1:0] ptr_sel; // register chosen by the pointer
  logic [7:0] input_level; // value the input register reports
  logic [7:0] read_val; // value of the selected register
  logic byte_end; // eighth bit received, clock now low
  logic addr_match; // received address is ours
  logic wr_cmd; // command byte complete
  logic wr_data; // data byte complete
  logic ack_rise_rd; // rising edge of an ack clock in a read
  logic tx_fall; // clock fall inside a sent byte

  // all pins cross into our clock before use
  assign raw_in = {scl_in, sda_in, addr_strap_2_in, addr_strap_1_in, addr_strap_0_in,
                   port_pin_in};

  sync2 #(.WIDTH(13)) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(raw_in),
    .sync_out(sync_q)
  );

  assign scl_s = sync_q[12];
  assign sda_s = sync_q[11];
  assign strap_s = sync_q[10:8];
  assign pin_s = sync_q[7:0];

  bus_cond u_cond (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .ev_out(ev)
  );

  // decode of the pointer and the register read path
  assign ptr_sel = register_pointer[1:0]; // RQ23
  assign input_level = pin_s ^ input_polarity_invert; // RQ6 RQ10
  assign read_val = (ptr_sel == SEL_INPUT) ? input_level :
                    (ptr_sel == SEL_OUTPUT) ? output_latch : // RQ9
                    (ptr_sel == SEL_INVERT) ? input_polarity_invert :
                    pin_direction; // RQ4

  // byte and event decode
  assign byte_end = (state == ST_RX) && ev.scl_fall && (bit_cnt == BIT_CNT_FULL);
  assign addr_match = rx_shift[7:1] == {ADDR_FIXED, strap_s}; // RQ1
  assign wr_cmd = byte_end && (phase == PH_CMD); // RQ3 RQ5
  assign wr_data = byte_end && (phase == PH_DATA);
  assign ack_rise_rd = ev.scl_rise && ((state == ST_ACK && rw_read) || state == ST_MACK);
  assign tx_fall = (state == ST_TX) && ev.scl_fall;

  // next engine state; start and stop win from any state
  always_comb begin
    next_state = state;
    if (ev.start) begin
      next_state = ST_RX; // repeated start keeps the pointer
    end else if (ev.stop) begin
      next_state = ST_IDLE; // RQ18
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_RX: begin
          // foreign address: stay off the bus until the next start
          if (byte_end) begin
            next_state = (phase != PH_ADDR || addr_match) ? ST_ACK : ST_IDLE; // RQ22
          end
        end
        ST_ACK: begin
          if (ev.scl_fall) begin
            next_state = rw_read ? ST_TX : ST_RX; // RQ2
          end
        end
        ST_TX: begin
          if (ev.scl_fall && bit_cnt == BIT_CNT_FULL) begin
            next_state = ST_MACK;
          end
        end
        ST_MACK: begin
          // a missing master ack ends the read
          if (ev.scl_fall) begin
            next_state = mack_ok ? ST_TX : ST_IDLE; // RQ16
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // outgoing byte: load at each ack rise of a read, shift on each inner fall
  assign next_tx_shift = ack_rise_rd ? read_val : // RQ15
                         (tx_fall && bit_cnt != BIT_CNT_FULL) ? {tx_shift[6:0], 1'b0} :
                         tx_shift;

  // data line: pulled low for acks and for zero bits sent
  always_comb begin
    next_sda_oe_n = 1'b1;
    if (next_state == ST_ACK) begin
      next_sda_oe_n = 1'b0; // RQ21
    end else if (next_state == ST_TX) begin
      next_sda_oe_n = next_tx_shift[7];
    end
  end

  // state and data line register
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE; // RQ24
      sda_oe_n_out <= 1'b1;
    end else begin
      state <= next_state;
      sda_oe_n_out <= next_sda_oe_n; // RQ18
    end
  end

  // bit counter restarts at each start and after every ack bit
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || ev.start || (ev.scl_fall && (state == ST_ACK || state == ST_MACK))) begin
      bit_cnt <= 4'h0;
    end else if (ev.scl_rise && (state == ST_RX || state == ST_TX)) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // shift registers; data is sampled while the clock is high
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
    end else begin
      if (ev.scl_rise && state == ST_RX) begin
        rx_shift <= {rx_shift[6:0], sda_s};
      end
      tx_shift <= next_tx_shift;
    end
  end

  // master ack seen on the ack clock rise
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      mack_ok <= 1'b0;
    end else if (ev.scl_rise && state == ST_MACK) begin
      mack_ok <= !sda_s;
    end
  end

  // byte role and direction of the transfer
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || ev.start) begin
      phase <= PH_ADDR;
      rw_read <= 1'b0;
    end else if (byte_end && phase == PH_ADDR && addr_match) begin
      phase <= PH_CMD;
      rw_read <= rx_shift[RW_BIT]; // RQ2 RQ13
    end else if (wr_cmd) begin
      phase <= PH_DATA; // RQ12
    end
  end

  // command byte; a read leaves it alone, so it keeps steering reads
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      register_pointer <= POINTER_RST; // RQ24 RQ17
    end else if (wr_cmd) begin
      register_pointer <= rx_shift; // RQ3 RQ5 RQ14
    end
  end

  // writable registers; a byte aimed at the input register is dropped
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      output_latch <= OUT_LATCH_RST;
      input_polarity_invert <= INVERT_RST;
      pin_direction <= DIR_RST;
    end else if (wr_data) begin
      if (ptr_sel == SEL_OUTPUT) begin
        output_latch <= rx_shift; // RQ12
      end
      if (ptr_sel == SEL_INVERT) begin
        input_polarity_invert <= rx_shift;
      end
      if (ptr_sel == SEL_DIR) begin
        pin_direction <= rx_shift; // RQ7
      end
    end
  end

  // pins: latch value always offered, driver enabled per direction bit
  assign port_pin_out = output_latch; // RQ8
  assign port_pin_oe_n_out = pin_direction; // RQ11
  assign sda_out = 1'b0;
  assign int_n_out = 1'b0;

  // interrupt compares input pins with the levels last read; a pin
  // returning to its old level clears it without any read
  assign int_pend = |((pin_s ^ in_snapshot) & pin_direction); // RQ19 RQ20

  // the synchronisers read all ones through reset, so the true pin
  // levels only arrive two cycles later; wait for them
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      settle_cnt <= 2'h0;
    end else if (settling) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end
  assign settling = settle_cnt != 2'h3;

  // snapshot taken while settling and at each input register ack rise;
  // a pin turned from output to input may raise a false interrupt
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      in_snapshot <= 8'hFF;
    end else if (settling || (ack_rise_rd && ptr_sel == SEL_INPUT)) begin
      in_snapshot <= pin_s; // RQ19
    end
  end

  // open-drain interrupt, registered; held off while settling
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      int_oe_n_out <= 1'b1;
    end else begin
      int_oe_n_out <= !(int_pend && !settling); // RQ19
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_byte_end;
    (state == ST_RX) && ev.scl_fall && (bit_cnt == BIT_CNT_FULL);
  endsequence

  sequence s_own_addr;
    s_byte_end ##0 (phase == PH_ADDR && addr_match);
  endsequence

  property p_addr_ack; // RQ1
    s_own_addr |=> (state == ST_ACK) && !sda_oe_n_out;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_rw_dir; // RQ2
    s_own_addr |=> rw_read == $past(rx_shift[0]);
  endproperty
  a_rw_dir: assert property (p_rw_dir) else $error("direction bit not taken");

  property p_ptr_store; // RQ3
    s_byte_end ##0 (phase == PH_CMD) |=> register_pointer == $past(rx_shift);
  endproperty
  a_ptr_store: assert property (p_ptr_store) else $error("command byte not stored");

  property p_in_discard; // RQ7
    s_byte_end ##0 (phase == PH_DATA && ptr_sel == SEL_INPUT) |=>
      $stable(output_latch) && $stable(input_polarity_invert) && $stable(pin_direction)
      && !sda_oe_n_out;
  endproperty
  a_in_discard: assert property (p_in_discard) else $error("input write changed state");

  property p_latch_store; // RQ12
    s_byte_end ##0 (phase == PH_DATA && ptr_sel == SEL_OUTPUT) |=>
      output_latch == $past(rx_shift);
  endproperty
  a_latch_store: assert property (p_latch_store) else $error("latch write lost");

  property p_pin_drive; // RQ8
    (port_pin_out & ~port_pin_oe_n_out) == (output_latch & ~pin_direction);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive mismatch");

  property p_stop_idle; // RQ18
    ev.stop |=> (state == ST_IDLE) && sda_oe_n_out;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not release");

  property p_capture; // RQ15
    ack_rise_rd |=> tx_shift == $past(read_val);
  endproperty
  a_capture: assert property (p_capture) else $error("read data not captured");

  property p_no_out_int; // RQ20
    (pin_direction == 8'h00) [*2] |=> int_oe_n_out;
  endproperty
  a_no_out_int: assert property (p_no_out_int) else $error("output pin raised interrupt");

  property p_addr_nack; // RQ22
    s_byte_end ##0 (phase == PH_ADDR && !addr_match) |=>
      (state == ST_IDLE) && sda_oe_n_out;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address touched bus");
endmodule

//--- rtl/sync2.sv
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // levels from outside this clock domain
  output logic [WIDTH-1:0] sync_out // levels after two flip-flops
);
  logic [WIDTH-1:0] meta; // first stage, read only by the second

  // resets high: idle bus lines and pulled-up pins read one
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- verif/link_master_model.sv
`timescale 1ns/1ns
// behavioural link master; its clock stands high between frames
module link_master_model (
  output logic scl_out, // link clock, idle high
  output logic sda_rel_out, // one releases data, zero pulls it low
  input wire logic sda_in // resolved data level, pulled up
);
  // idle bus at time zero
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  // start, or repeated start when the clock is low
  task automatic start_cond();
    if (!scl_out) begin
      #62 sda_rel_out = 1'b1;
      #13 scl_out = 1'b1;
      #60;
    end
    sda_rel_out = 1'b0;
    #60 scl_out = 1'b0;
  endtask

  // one 125 ns clock; data moves 62 ns after the fall so the hold time is kept
  task automatic clk_bit(input logic b, output logic r);
    #62 sda_rel_out = b;
    #13 scl_out = 1'b1;
    #30 r = sda_in;
    #20 scl_out = 1'b0;
  endtask

  // shift n bits, most significant first; a short count leaves a partial byte
  task automatic shift_bits(input logic [7:0] d, input int n, output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--) begin
      clk_bit(d[i], q[i]);
    end
  endtask

  // stop: data low under a high clock, then data rises
  task automatic stop_cond();
    #62 sda_rel_out = 1'b0;
    #13 scl_out = 1'b1;
    #60 sda_rel_out = 1'b1;
    #60;
  endtask
endmodule

//--- verif/serial_eight_bit_io_expander_test.sv
`timescale 1ns/1ns
module serial_eight_bit_io_expander_test;
  import expander_pkg::*;
  logic clk; // system clock
  logic rst_n; // reset, active low
  logic scl; // link clock from the master
  logic sda_rel; // master data release
  logic [2:0] strap; // address straps
  logic [7:0] pins; // levels seen on the port pins
  logic [7:0] pin_drv; // port drive values
  logic [7:0] pin_oe_n; // port drive enables, low drives
  logic [7:0] q0; // first byte read
  logic [7:0] q1; // second byte read
  logic sda_drv; // device data value
  logic sda_oe_n; // device pulls data low when low
  logic int_drv; // interrupt value
  logic int_oe_n; // interrupt raised when low
  wire sda; // resolved data wire with pull-up
  int fails;
  int samples_checked;

  // open drain: anyone enabled pulls the line low
  assign sda = sda_rel & (sda_oe_n | sda_drv);

  always #5 clk = ~clk;

  link_master_model u_master (
    .scl_out(scl),
    .sda_rel_out(sda_rel),
    .sda_in(sda)
  );

  serial_eight_bit_io_expander u_dut (
    .ref_clk_in(clk),
    .nrst_in(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_drv),
    .sda_oe_n_out(sda_oe_n),
    .addr_strap_0_in(strap[0]),
    .addr_strap_1_in(strap[1]),
    .addr_strap_2_in(strap[2]),
    .port_pin_in(pins),
    .port_pin_out(pin_drv),
    .port_pin_oe_n_out(pin_oe_n),
    .int_n_out(int_drv),
    .int_oe_n_out(int_oe_n)
  );

  // one comparison, counted
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pins move just after a clock edge
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk);
    #1 pins = v;
  endtask

  // send one byte and expect the device to pull the ack low
  task automatic send(input logic [7:0] d);
    logic a;
    logic [7:0] q;
    u_master.shift_bits(d, 8, q);
    u_master.clk_bit(1'b1, a);
    check("ack", {7'h00, a}, 8'h00);
  endtask

  // write transfer with one or two data bytes
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    u_master.start_cond();
    send({ADDR_FIXED, strap, 1'b0});
    send(cmd);
    send(d0);
    if (n == 2) begin
      send(d1);
    end
    u_master.stop_cond();
  endtask

  // read transfer, with or without a command; pins change between two bytes
  task automatic rd(input logic use_cmd, input logic [7:0] cmd, input int n,
                    input logic [7:0] mid);
    logic a;
    u_master.start_cond();
    if (use_cmd) begin
      send({ADDR_FIXED, strap, 1'b0});
      send(cmd);
      u_master.start_cond();
    end
    send({ADDR_FIXED, strap, 1'b1});
    u_master.shift_bits(8'hFF, 8, q0);
    if (n == 2) begin
      set_pins(mid);
      u_master.clk_bit(1'b0, a);
      u_master.shift_bits(8'hFF, 8, q1);
    end
    u_master.clk_bit(1'b1, a);
    u_master.stop_cond();
  endtask

  // reset values, then a read with no command byte
  task automatic t_reset();
    check("pin_out", pin_drv, OUT_LATCH_RST);
    check("pin_oe_n", pin_oe_n, DIR_RST);
    check("int_oe_n", {7'h00, int_oe_n}, 8'h01);
    check("sda_oe_n", {7'h00, sda_oe_n}, 8'h01);
    rd(1'b0, 8'h00, 1, 8'h00);
    check("input direct", q0, 8'h5A);
  endtask

  // every strap setting answers; a neighbour address does not
  task automatic t_address();
    logic a;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      #1 strap = s[2:0];
      repeat (4) @(posedge clk);
      u_master.start_cond();
      send({ADDR_FIXED, s[2:0], 1'b0});
      u_master.stop_cond();
      u_master.start_cond();
      u_master.shift_bits({ADDR_FIXED, s[2:0] ^ 3'h1, 1'b0}, 8, q0);
      u_master.clk_bit(1'b1, a);
      check("wrong address", {7'h00, a}, 8'h01);
      u_master.stop_cond();
    end
  endtask

  // direction and latch writes, then a discarded write to the input register
  task automatic t_write();
    wr(8'h03, 8'h0F, 8'h00, 1);
    wr(8'hFD, 8'h33, 8'hC6, 2);
    check("pin_oe_n", pin_oe_n, 8'h0F);
    check("pin_out", pin_drv, 8'hC6);
    wr(8'h00, 8'h12, 8'h00, 1);
    check("pin_out kept", pin_drv, 8'hC6);
    check("pin_oe_n kept", pin_oe_n, 8'h0F);
  endtask

  // read back through restart; the pointer persists between reads
  task automatic t_readback();
    rd(1'b1, 8'h01, 1, 8'h00);
    check("latch", q0, 8'hC6);
    rd(1'b1, 8'hF3, 1, 8'h00);
    check("dir", q0, 8'h0F);
    rd(1'b0, 8'h00, 1, 8'h00);
    check("dir again", q0, 8'h0F);
  endtask

  // inversion, and a two byte read that sees pins move
  task automatic t_polarity();
    wr(8'h02, 8'hA5, 8'h00, 1);
    rd(1'b1, 8'h02, 1, 8'h00);
    check("invert", q0, 8'hA5);
    rd(1'b1, 8'h00, 2, 8'h3C);
    check("input", q0, 8'h5A ^ 8'hA5);
    check("input fresh", q1, 8'h3C ^ 8'hA5);
  endtask

  // stop in the middle of a command byte; the partial byte is dropped
  task automatic t_stop_mid();
    u_master.start_cond();
    send({ADDR_FIXED, strap, 1'b0});
    u_master.shift_bits(8'hF0, 4, q0);
    u_master.stop_cond();
    check("sda released", {7'h00, sda_oe_n}, 8'h01);
    rd(1'b0, 8'h00, 1, 8'h00);
    check("after stop", q0, 8'h3C ^ 8'hA5);
  endtask

  // output pins stay quiet; input edges raise, return or read clears
  task automatic t_interrupt();
    check("int idle", {7'h00, int_oe_n}, 8'h01);
    set_pins(8'hBC);
    repeat (8) @(posedge clk);
    check("int output pin", {7'h00, int_oe_n}, 8'h01);
    set_pins(8'hBD);
    repeat (8) @(posedge clk);
    check("int raised", {7'h00, int_oe_n}, 8'h00);
    set_pins(8'hBC);
    repeat (8) @(posedge clk);
    check("int returned", {7'h00, int_oe_n}, 8'h01);
    set_pins(8'hBD);
    repeat (8) @(posedge clk);
    rd(1'b0, 8'h00, 1, 8'h00);
    check("input", q0, 8'hBD ^ 8'hA5);
    check("int read", {7'h00, int_oe_n}, 8'h01);
    wr(8'h03, 8'h00, 8'h00, 1);
    set_pins(8'h42);
    repeat (8) @(posedge clk);
    check("int all outputs", {7'h00, int_oe_n}, 8'h01);
  endtask

  // counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence; pins stay stable through reset for the snapshot
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    strap = 3'h5;
    pins = 8'h5A;
    fails = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_address();
    t_write();
    t_readback();
    t_polarity();
    t_stop_mid();
    t_interrupt();
    complete_run();
  end

  // watchdog, far beyond the roughly 75 us the tests need
  initial begin
    #900000;
    fails++;
    complete_run();
  end
endmodule
